// ### rtl/tcu_pkg.sv
package tcu_pkg;
   // ==========================================================
   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ==========================================================
   // Register indices
   localparam logic [3:0] A_TCTL  = 4'h0; // timer_control_register
   localparam logic [3:0] A_TMODE = 4'h1; // timer_mode_register
   localparam logic [3:0] A_LO0   = 4'h2; // first_timer_low_byte
   localparam logic [3:0] A_LO1   = 4'h3;
   localparam logic [3:0] A_HI0   = 4'h4; // first_timer_high_byte
   localparam logic [3:0] A_HI1   = 4'h5;
   localparam logic [3:0] A_CKCTL = 4'h6; // clock_control_register
   localparam logic [3:0] A_T2CTL = 4'h8; // third_timer_control_register
   localparam logic [3:0] A_T2MD  = 4'h9; // third_timer_mode_register
   localparam logic [3:0] A_CAPL  = 4'ha; // capture_low_register
   localparam logic [3:0] A_CAPH  = 4'hb; // capture_high_register
   localparam logic [3:0] A_LO2   = 4'hc;
   localparam logic [3:0] A_HI2   = 4'hd;

   // ==========================================================
   // Field positions
   localparam int B_TF1  = 7; // timer control
   localparam int B_TR1  = 6;
   localparam int B_TF0  = 5;
   localparam int B_TR0  = 4;
   localparam int B_GT1  = 7; // timer mode
   localparam int B_CT1  = 6;
   localparam int B_M1   = 4;
   localparam int B_GT0  = 3;
   localparam int B_CT0  = 2;
   localparam int B_M0   = 0;
   localparam int B_TB0  = 3; // clock control, turbo selects
   localparam int B_TB1  = 4;
   localparam int B_TB2  = 5;
   localparam int B_TF2  = 7; // third timer control
   localparam int B_EXF  = 6;
   localparam int B_RBD  = 5;
   localparam int B_TBD  = 4;
   localparam int B_EXEN = 3;
   localparam int B_TR2  = 2;
   localparam int B_CT2  = 1;
   localparam int B_CPRL = 0;
   localparam int B_CCLR = 3; // third timer mode
   localparam int B_COE  = 1;
   localparam int B_DOWN_COUNT_ENABLE = 0;

   // Pin vector positions
   localparam int P_C0 = 0;
   localparam int P_C1 = 1;
   localparam int P_C2 = 2;
   localparam int P_I0 = 3;
   localparam int P_I1 = 4;
   localparam int P_TG = 5;
   localparam int NPIN = 6;

   // ==========================================================
   // Reset values and timing
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam int         DIV_STD   = 12;
   localparam int         DIV_TURBO = 4;
   localparam logic [3:0] PRE_LAST  = 4'(DIV_STD - 1);
   localparam logic [1:0] MC_LAST   = 2'(DIV_TURBO - 1);

   // ==========================================================
   // Modes
   typedef enum logic [1:0] {TCU_M13, TCU_M16, TCU_M8R, TCU_MSPLIT} tcu_mode_t;
   typedef enum logic [1:0] {TCU_T2_REL, TCU_T2_CAP, TCU_T2_UPDN, TCU_T2_BAUD} tcu_t2mode_t;
endpackage : tcu_pkg

// ### rtl/tcu_timers.sv
// Behaviour
// (R1) Mode 0: 13-bit count, high byte plus low 5 bits, wraps 1FFF.
// (R2) Mode 0: low-5 carry bumps high byte; high wrap sets overflow flag.
// (R3) Timers 0/1 count only if run set and gate clear or pin high.
// (R4) Source select 0 counts time base, 1 counts count-pin falls.
// (R5) Time base is clock/12, or clock/4 with turbo select.
// (R6) Mode 1: 16-bit count, FFFF to 0000 sets overflow flag.
// (R7) Mode 2: low byte counts, reloads from high byte, sets flag.
// (R8) Timer 1 in mode 3 holds its count.
// (R9) Timer 0 mode 3: low byte is 8-bit counter on timer 0 controls.
// (R10) Timer 0 mode 3: high byte times, run by and flags timer 1 bits.
// (R11) Timer 0 mode 3: timer 1 runs free of its run bit and flag.
// (R12) Timer 2 counts pin or clock/12 or /4 while its run bit set.
// (R13) Capture mode: 16-bit up count, FFFF rollover sets overflow flag.
// (R14) Capture mode: trigger fall copies count to capture, sets event flag.
// (R15) Capture-clear enable clears timer 2 after each capture.
// (R16) Up auto-reload: FFFF rollover loads capture value, sets overflow flag.
// (R17) Up auto-reload: trigger fall also reloads and sets event flag.
// (R18) Up/down mode: trigger level sets direction; up overflow reloads.
// (R19) Up/down: down count from capture value loads FFFF.
// (R20) Up/down: reloads set overflow, toggle event flag, no event request.
// (R21) Baud mode: reload from FFFF without flag; trigger sets event flag.
// (R22) Clock-out: output enable drives 50% clock, no overflow flag.
// (R23) Pins sampled once per machine cycle; high then low is a fall.
// (R24) Reset clears turbo selects, timers count at clock/12.
// (R25) Clock output toggles on every timer 2 reload while output enable is set.
// (R26) Trigger pin falls detected like the count pins.
module tcu_timers (
   // Clock, reset, enable
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_ce,
   // Register port
   input  wire logic [tcu_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [tcu_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [tcu_pkg::DATA_W-1:0] o_rdata,
   // External pins
   input  wire logic                        i_first_count_pin,
   input  wire logic                        i_second_count_pin,
   input  wire logic                        i_third_count_pin,
   input  wire logic                        i_first_interrupt_pin,
   input  wire logic                        i_second_interrupt_pin,
   input  wire logic                        i_trigger_pin,
   // Flags and clock out
   output logic                             o_first_overflow_flag,
   output logic                             o_second_overflow_flag,
   output logic                             o_third_overflow_flag,
   output logic                             o_external_event_req,
   output logic                             o_clock_out
);
   import tcu_pkg::*;

   // ==========================================================
   // Registers
   logic [7:0]  tctl, tmode, ckctl, t2ctl, t2md;
   logic [7:0]  lo0, hi0, lo1, hi1, lo2, hi2, capl, caph;
   logic [3:0]  pre;
   logic [NPIN-1:0] sy1, sy2, samp, evt;

   // Decoded controls
   tcu_mode_t   m0, m1;
   tcu_t2mode_t t2m;
   logic        tick12, tick4, tb0, tb1, tb2, t0split;
   logic        step0, step0h, step1, step2, trg;
   logic [16:0] n0, n1;
   logic [15:0] cnt2, cap, next_cnt2;
   logic        set_tf0, set_tf1, set_tf2, set_exf, tog_exf, do_cap, rl;
   logic [7:0]  next_tctl, next_t2ctl;
   logic        wr_lo0, wr_hi0, wr_lo1, wr_hi1, wr_lo2, wr_hi2;

   assign wr_lo0 = i_wr && (i_addr == A_LO0);
   assign wr_hi0 = i_wr && (i_addr == A_HI0);
   assign wr_lo1 = i_wr && (i_addr == A_LO1);
   assign wr_hi1 = i_wr && (i_addr == A_HI1);
   assign wr_lo2 = i_wr && (i_addr == A_LO2);
   assign wr_hi2 = i_wr && (i_addr == A_HI2);

   // One count step for timers 0/1: {overflow, high, low}
   function automatic logic [16:0] step01(input tcu_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      case (m)
         // (R1) 13-bit prescaled count
         TCU_M13: begin
            r[4:0] = lo[4:0] + 5'h01;
            // (R2) carry into high byte
            if (lo[4:0] == 5'h1f) begin
               r[15:8] = hi + 8'h01;
               r[16]   = (hi == 8'hff);
            end
         end
         // (R6) full 16-bit count
         TCU_M16: r = {({hi, lo} == 16'hffff), {hi, lo} + 16'h0001};
         // (R7) low byte reloads from high
         TCU_M8R: begin
            if (lo == 8'hff) r = {1'b1, hi, hi};
            else             r[7:0] = lo + 8'h01;
         end
         // (R9) split low byte as 8-bit counter
         default: begin
            r[7:0] = lo + 8'h01;
            r[16]  = (lo == 8'hff);
         end
      endcase
      return r;
   endfunction : step01

   // ==========================================================
   // Time base
   assign tick12 = (pre == PRE_LAST);
   assign tick4  = (pre[1:0] == MC_LAST);
   // (R5) per-timer divide select
   assign tb0 = ckctl[B_TB0] ? tick4 : tick12;
   assign tb1 = ckctl[B_TB1] ? tick4 : tick12;
   assign tb2 = ckctl[B_TB2] ? tick4 : tick12;

   // Prescaler, 0..11
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n)  pre <= 4'h0;
      else if (i_ce) pre <= tick12 ? 4'h0 : pre + 4'h1;
   end

   // Pin synchronisers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sy1 <= '0;
         sy2 <= '0;
      end else if (i_ce) begin
         sy1 <= {i_trigger_pin, i_second_interrupt_pin, i_first_interrupt_pin,
                 i_third_count_pin, i_second_count_pin, i_first_count_pin};
         sy2 <= sy1;
      end
   end

   // (R23) machine-cycle sampling, fall pulse
   // (R26) trigger sampled alike
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         samp <= '0;
         evt  <= '0;
      end else if (i_ce) begin
         if (tick4) begin
            samp <= sy2;
            evt  <= samp & ~sy2;
         end else begin
            evt  <= '0;
         end
      end
   end

   // ==========================================================
   // Timers 0 and 1 step logic
   assign m0      = tcu_mode_t'(tmode[B_M0 +: 2]);
   assign m1      = tcu_mode_t'(tmode[B_M1 +: 2]);
   assign t0split = (m0 == TCU_MSPLIT);

   always_comb begin
      // (R3) run and gate qualify counting
      // (R4) time base or pin falls
      step0  = tctl[B_TR0] && (!tmode[B_GT0] || sy2[P_I0])
               && (tmode[B_CT0] ? evt[P_C0] : tb0);
      // (R10) split high byte on timer 1 run
      step0h = t0split && tctl[B_TR1] && tb0;
      // (R11) timer 1 run bit lost in split
      // (R8) mode 3 freezes timer 1
      step1  = (t0split || tctl[B_TR1]) && (!tmode[B_GT1] || sy2[P_I1])
               && (tmode[B_CT1] ? evt[P_C1] : tb1) && (m1 != TCU_MSPLIT);
      n0      = step01(m0, hi0, lo0);
      n1      = step01(m1, hi1, lo1);
      set_tf0 = step0 && n0[16];
      set_tf1 = t0split ? (step0h && (hi0 == 8'hff)) : (step1 && n1[16]);
      next_tctl = (i_wr && (i_addr == A_TCTL)) ? i_wdata : tctl;
      next_tctl[B_TF0] = next_tctl[B_TF0] | set_tf0;
      next_tctl[B_TF1] = next_tctl[B_TF1] | set_tf1;
   end

   // Timer 0 count bytes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         lo0 <= RST_BYTE;
         hi0 <= RST_BYTE;
      end else if (i_ce) begin
         if (wr_lo0)     lo0 <= i_wdata;
         else if (step0) lo0 <= n0[7:0];
         if (wr_hi0)                  hi0 <= i_wdata;
         else if (step0h)             hi0 <= hi0 + 8'h01;
         else if (step0 && !t0split)  hi0 <= n0[15:8];
      end
   end

   // Timer 1 count bytes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         lo1 <= RST_BYTE;
         hi1 <= RST_BYTE;
      end else if (i_ce) begin
         if (wr_lo1)     lo1 <= i_wdata;
         else if (step1) lo1 <= n1[7:0];
         if (wr_hi1)     hi1 <= i_wdata;
         else if (step1) hi1 <= n1[15:8];
      end
   end

   // ==========================================================
   // Timer 2 step logic
   assign cnt2 = {hi2, lo2};
   assign cap  = {caph, capl};

   always_comb begin
      if (t2ctl[B_CPRL] && !(t2ctl[B_RBD] || t2ctl[B_TBD])) t2m = TCU_T2_CAP;
      else if (t2ctl[B_RBD] || t2ctl[B_TBD] || t2md[B_COE]) t2m = TCU_T2_BAUD;
      else if (t2md[B_DOWN_COUNT_ENABLE])                                 t2m = TCU_T2_UPDN;
      else                                                   t2m = TCU_T2_REL;
   end

   always_comb begin
      // (R12) source and run bit
      step2     = t2ctl[B_TR2] && (t2ctl[B_CT2] ? evt[P_C2] : tb2);
      trg       = t2ctl[B_EXEN] && evt[P_TG];
      next_cnt2 = cnt2;
      set_tf2   = 1'b0;
      set_exf   = 1'b0;
      tog_exf   = 1'b0;
      do_cap    = 1'b0;
      rl        = 1'b0;
      case (t2m)
         TCU_T2_CAP: begin
            // (R13) plain up count
            if (step2) begin
               next_cnt2 = cnt2 + 16'h0001;
               set_tf2   = (cnt2 == 16'hffff);
            end
            // (R14) capture on trigger
            if (trg) begin
               do_cap  = 1'b1;
               set_exf = 1'b1;
               // (R15) clear after capture
               if (t2md[B_CCLR]) next_cnt2 = 16'h0000;
            end
         end
         TCU_T2_UPDN: begin
            // (R18) trigger level is direction
            if (step2 && sy2[P_TG]) begin
               rl        = (cnt2 == 16'hffff);
               next_cnt2 = rl ? cap : cnt2 + 16'h0001;
            end else if (step2) begin
               // (R19) underflow past capture value
               rl        = (cnt2 == cap);
               next_cnt2 = rl ? 16'hffff : cnt2 - 16'h0001;
            end
            // (R20) reload sets and toggles flags
            set_tf2 = rl;
            tog_exf = rl;
         end
         TCU_T2_BAUD: begin
            // (R21) reload without overflow flag
            // (R22) clock-out shares this path
            if (step2 && (cnt2 == 16'hffff)) begin
               rl        = 1'b1;
               next_cnt2 = cap;
            end
            set_exf = trg;
         end
         default: begin
            // (R16) rollover reload
            if (step2 && (cnt2 == 16'hffff)) begin
               rl        = 1'b1;
               next_cnt2 = cap;
            end else if (step2) begin
               next_cnt2 = cnt2 + 16'h0001;
            end
            // (R17) trigger reload
            if (trg) begin
               next_cnt2 = cap;
               set_exf   = 1'b1;
            end
            set_tf2 = rl;
         end
      endcase
      if (t2m == TCU_T2_BAUD && step2 && cnt2 != 16'hffff) next_cnt2 = cnt2 + 16'h0001;
      next_t2ctl = (i_wr && (i_addr == A_T2CTL)) ? i_wdata : t2ctl;
      next_t2ctl[B_TF2] = next_t2ctl[B_TF2] | set_tf2;
      next_t2ctl[B_EXF] = (next_t2ctl[B_EXF] ^ tog_exf) | set_exf;
   end

   // Timer 2 count and capture registers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         lo2  <= RST_BYTE;
         hi2  <= RST_BYTE;
         capl <= RST_BYTE;
         caph <= RST_BYTE;
      end else if (i_ce) begin
         lo2 <= wr_lo2 ? i_wdata : next_cnt2[7:0];
         hi2 <= wr_hi2 ? i_wdata : next_cnt2[15:8];
         if (do_cap) begin
            capl <= lo2;
            caph <= hi2;
         end else begin
            if (i_wr && (i_addr == A_CAPL)) capl <= i_wdata;
            if (i_wr && (i_addr == A_CAPH)) caph <= i_wdata;
         end
      end
   end

   // ==========================================================
   // Control registers, hardware set beats software clear
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         tctl  <= RST_BYTE;
         tmode <= RST_BYTE;
         ckctl <= RST_BYTE; // (R24) turbo selects cleared
         t2ctl <= RST_BYTE;
         t2md  <= RST_BYTE;
      end else if (i_ce) begin
         tctl  <= next_tctl;
         t2ctl <= next_t2ctl;
         if (i_wr && (i_addr == A_TMODE)) tmode <= i_wdata;
         if (i_wr && (i_addr == A_CKCTL)) ckctl <= i_wdata;
         if (i_wr && (i_addr == A_T2MD))  t2md  <= i_wdata;
      end
   end

   // Read data, valid only the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_rdata <= RST_BYTE;
      end else if (i_ce) begin
         if (!i_rd) begin
            o_rdata <= RST_BYTE;
         end else begin
            case (i_addr)
               A_TCTL:  o_rdata <= tctl;
               A_TMODE: o_rdata <= tmode;
               A_LO0:   o_rdata <= lo0;
               A_LO1:   o_rdata <= lo1;
               A_HI0:   o_rdata <= hi0;
               A_HI1:   o_rdata <= hi1;
               A_CKCTL: o_rdata <= ckctl;
               A_T2CTL: o_rdata <= t2ctl;
               A_T2MD:  o_rdata <= t2md;
               A_CAPL:  o_rdata <= capl;
               A_CAPH:  o_rdata <= caph;
               A_LO2:   o_rdata <= lo2;
               A_HI2:   o_rdata <= hi2;
               default: o_rdata <= RST_BYTE;
            endcase
         end
      end
   end

   // Flag outputs and clock out
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_first_overflow_flag  <= 1'b0;
         o_second_overflow_flag <= 1'b0;
         o_third_overflow_flag  <= 1'b0;
         o_external_event_req   <= 1'b0;
         o_clock_out            <= 1'b0;
      end else if (i_ce) begin
         o_first_overflow_flag  <= next_tctl[B_TF0];
         o_second_overflow_flag <= next_tctl[B_TF1];
         o_third_overflow_flag  <= next_t2ctl[B_TF2];
         // (R20) no event request in up/down
         o_external_event_req   <= next_t2ctl[B_EXF] && (t2m != TCU_T2_UPDN);
         // (R25) toggle per reload
         // (R22) only with output enable
         if (rl && t2md[B_COE]) o_clock_out <= !o_clock_out;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   sequence s_m0_top;
      i_ce && step0 && m0 == TCU_M13 && {hi0, lo0[4:0]} == 13'h1fff && !wr_lo0 && !wr_hi0;
   endsequence
   property p_r1_wrap;
      s_m0_top |=> hi0 == 8'h00 && lo0[4:0] == 5'h00 && tctl[B_TF0];
   endproperty
   a_r1_wrap: assert property (p_r1_wrap) else $error("mode 0 wrap wrong"); // (R1)

   property p_r3_hold;
      i_ce && !tctl[B_TR0] && !wr_lo0 |=> $stable(lo0);
   endproperty
   a_r3_hold: assert property (p_r3_hold) else $error("timer 0 counted while stopped"); // (R3)

   property p_r5_std;
      i_ce && tick12 |=> !tick12 [*8];
   endproperty
   a_r5_std: assert property (p_r5_std) else $error("clock/12 tick too close"); // (R5)

   property p_r7_reload;
      i_ce && step0 && m0 == TCU_M8R && lo0 == 8'hff && !wr_lo0 && !wr_hi0
      |=> lo0 == $past(hi0) && tctl[B_TF0];
   endproperty
   a_r7_reload: assert property (p_r7_reload) else $error("mode 2 reload wrong"); // (R7)

   property p_r8_freeze;
      i_ce && m1 == TCU_MSPLIT && !wr_lo1 && !wr_hi1 |=> $stable({hi1, lo1});
   endproperty
   a_r8_freeze: assert property (p_r8_freeze) else $error("timer 1 moved in mode 3"); // (R8)

   sequence s_t2_top;
      i_ce && step2 && t2m == TCU_T2_REL && cnt2 == 16'hffff && !trg && !wr_lo2 && !wr_hi2;
   endsequence
   property p_r16_reload;
      s_t2_top |=> cnt2 == $past(cap) && t2ctl[B_TF2];
   endproperty
   a_r16_reload: assert property (p_r16_reload) else $error("timer 2 reload wrong"); // (R16)

   property p_r19_under;
      i_ce && step2 && t2m == TCU_T2_UPDN && !sy2[P_TG] && cnt2 == cap && !wr_lo2 && !wr_hi2
      |=> cnt2 == 16'hffff;
   endproperty
   a_r19_under: assert property (p_r19_under) else $error("down reload not FFFF"); // (R19)

   property p_r21_noflag;
      i_ce && t2m == TCU_T2_BAUD && !(i_wr && i_addr == A_T2CTL) |=> $stable(t2ctl[B_TF2]);
   endproperty
   a_r21_noflag: assert property (p_r21_noflag) else $error("baud mode set flag"); // (R21)

   property p_r23_fall;
      evt[P_C0] |-> !samp[P_C0] && $past(samp[P_C0]);
   endproperty
   a_r23_fall: assert property (p_r23_fall) else $error("fall without high-low samples"); // (R23)

   property p_r24_reset;
      $rose(i_rst_n) |-> ckctl[B_TB0] == 1'b0 && ckctl[B_TB1] == 1'b0;
   endproperty
   a_r24_reset: assert property (p_r24_reset) else $error("turbo selects not cleared"); // (R24)
endmodule : tcu_timers

// ### test/tcu_pins.sv
module tcu_pins (
   // Clock
   input  wire logic                      i_mclk,
   // Bench commands
   input  wire logic [tcu_pkg::NPIN-1:0] i_fire,
   input  wire logic [tcu_pkg::NPIN-1:0] i_level,
   // Pins toward the timers
   output logic      [tcu_pkg::NPIN-1:0] o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   import tcu_pkg::*;

   // ==========================================================
   // Low pulse stretchers
   logic [3:0] low_cnt [NPIN] = '{default: 4'h0};

   always @(posedge i_mclk) begin
      for (int k = 0; k < NPIN; k++) begin
         if (i_fire[k]) begin
            low_cnt[k] <= 4'hc; // Three machine cycles low
         end else if (low_cnt[k] != 4'h0) begin
            low_cnt[k] <= low_cnt[k] - 4'h1;
         end
      end
   end

   // Pin level is the rest level, pulled low while a pulse runs
   always_comb begin
      for (int k = 0; k < NPIN; k++) begin
         o_pin[k] = i_level[k] & (low_cnt[k] == 4'h0);
      end
   end
endmodule : tcu_pins

// ### test/three_timer_counter_unit_bench.sv
module three_timer_counter_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tcu_pkg::*;

   // ==========================================================
   // Stimulus and observation
   logic       i_mclk  = 1'b0;
   logic       i_rst_n = 1'b0;
   logic [3:0] i_addr  = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr    = 1'b0;
   logic       i_rd    = 1'b0;
   logic       ce      = 1'b1;
   logic [5:0] fire    = 6'h00;
   logic [5:0] lvl     = 6'h3f;
   logic [7:0] o_rdata;
   logic [5:0] pin;
   logic       o0, o1, o2, oe, oc;
   logic [4:0] s;
   int         errors  = 0;
   int         n_tests = 0;
   int         cyc     = 0;

   // Observed outputs in one vector
   assign s = {oc, oe, o2, o1, o0};

   tcu_pins u_pins (.i_mclk(i_mclk), .i_fire(fire), .i_level(lvl), .o_pin(pin));

   tcu_timers u_dut (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_first_count_pin(pin[P_C0]), .i_second_count_pin(pin[P_C1]),
      .i_third_count_pin(pin[P_C2]), .i_first_interrupt_pin(pin[P_I0]),
      .i_second_interrupt_pin(pin[P_I1]), .i_trigger_pin(pin[P_TG]),
      .o_first_overflow_flag(o0), .o_second_overflow_flag(o1),
      .o_third_overflow_flag(o2), .o_external_event_req(oe), .o_clock_out(oc));

   // Clock, 8 ns period
   initial begin
      forever #4 i_mclk = ~i_mclk;
   end

   // ==========================================================
   // Shared tasks
   task automatic ck(input logic c, input string m);
      n_tests++;
      if (c !== 1'b1) begin
         errors++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask : ck

   task automatic endt(input string t);
      $display("test %s done", t);
   endtask : endt

   task automatic rst;
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      lvl     <= 6'h3f;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
   endtask : rst

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 ck(o_rdata === e, "read data mismatch");
   endtask : rd

   // Wait for an output to rise, bounded, and check the delay
   task automatic wt(input int k, input int lo, input int hi);
      int n;
      n = 0;
      while (s[k] !== 1'b1 && n < hi) begin
         @(posedge i_mclk);
         #1 n++;
      end
      ck(n >= lo && n < hi, "output rise timing");
   endtask : wt

   task automatic nv(input int k, input int n);
      int z;
      z = 0;
      repeat (n) begin
         @(posedge i_mclk);
         #1 z += (s[k] !== 1'b0);
      end
      ck(z == 0, "unexpected output rise");
   endtask : nv

   task automatic pulse(input int k);
      @(posedge i_mclk);
      fire[k] <= 1'b1;
      @(posedge i_mclk);
      fire[k] <= 1'b0;
   endtask : pulse

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rst();
      rd(A_CKCTL, 8'h00);
      rd(A_TCTL, 8'h00);
      wr(A_CAPL, 8'h5a);
      rd(A_CAPL, 8'h5a);
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      endt("registers");
   endtask : t_regs

   task automatic t_m0;
      rst();
      wr(A_HI0, 8'hff);
      wr(A_LO0, 8'hfc);
      wr(A_TCTL, 8'h10);
      wt(0, 34, 56);
      wr(A_TCTL, 8'h00);
      rd(A_HI0, 8'h00);
      endt("mode0");
   endtask : t_m0

   task automatic t_m1;
      rst();
      wr(A_CKCTL, 8'h10);
      wr(A_TMODE, 8'h10);
      wr(A_HI1, 8'hff);
      wr(A_LO1, 8'hfc);
      wr(A_TCTL, 8'h40);
      @(posedge i_mclk);
      ce <= 1'b0;
      nv(1, 40); // Clock enable freezes count
      ce <= 1'b1;
      wt(1, 10, 24);
      endt("mode1");
   endtask : t_m1

   task automatic t_m2;
      rst();
      wr(A_TMODE, 8'h02);
      wr(A_HI0, 8'ha5);
      wr(A_LO0, 8'hfe);
      wr(A_TCTL, 8'h10);
      wt(0, 12, 40);
      wr(A_TCTL, 8'h00);
      rd(A_LO0, 8'ha5);
      rd(A_HI0, 8'ha5);
      endt("mode2");
   endtask : t_m2

   task automatic t_gate;
      rst();
      @(posedge i_mclk);
      lvl[P_I0] <= 1'b0;
      wr(A_TMODE, 8'h09);
      wr(A_CKCTL, 8'h08);
      wr(A_HI0, 8'hff);
      wr(A_LO0, 8'hff);
      wr(A_TCTL, 8'h10);
      nv(0, 40);
      @(posedge i_mclk);
      lvl[P_I0] <= 1'b1;
      wt(0, 0, 20);
      endt("gate");
   endtask : t_gate

   task automatic t_pin;
      rst();
      wr(A_TMODE, 8'h50);
      wr(A_HI1, 8'hff);
      wr(A_LO1, 8'hff);
      wr(A_TCTL, 8'h40);
      nv(1, 40);
      pulse(P_C1);
      wt(1, 0, 40);
      endt("count pin");
   endtask : t_pin

   task automatic t_m3;
      rst();
      wr(A_TMODE, 8'h33);
      wr(A_HI0, 8'hff);
      wr(A_LO0, 8'hff);
      wr(A_LO1, 8'h77);
      wr(A_TCTL, 8'h40);
      wt(1, 0, 30);
      ck(o0 === 1'b0, "low half ran on wrong run bit");
      rd(A_LO1, 8'h77);
      wr(A_TCTL, 8'h10);
      wt(0, 0, 30);
      wr(A_TMODE, 8'h23);
      wr(A_LO1, 8'hff);
      nv(1, 30);
      endt("mode3");
   endtask : t_m3

   task automatic t_cap;
      rst();
      wr(A_T2MD, 8'h08);
      wr(A_LO2, 8'h34);
      wr(A_HI2, 8'h12);
      wr(A_T2CTL, 8'h0f);
      pulse(P_TG);
      wt(3, 0, 40);
      rd(A_CAPL, 8'h34);
      rd(A_CAPH, 8'h12);
      rd(A_LO2, 8'h00);
      wr(A_LO2, 8'hff);
      wr(A_HI2, 8'hff);
      pulse(P_C2);
      wt(2, 0, 40);
      endt("capture");
   endtask : t_cap

   task automatic t_rel;
      rst();
      wr(A_CAPH, 8'h80);
      wr(A_LO2, 8'hff);
      wr(A_HI2, 8'hff);
      wr(A_T2CTL, 8'h0e);
      pulse(P_C2);
      wt(2, 0, 40);
      rd(A_HI2, 8'h80);
      rd(A_LO2, 8'h00);
      wr(A_LO2, 8'h55);
      pulse(P_TG);
      wt(3, 0, 40);
      rd(A_LO2, 8'h00);
      endt("reload");
   endtask : t_rel

   task automatic t_ud;
      rst();
      @(posedge i_mclk);
      lvl[P_TG] <= 1'b0;
      wr(A_T2MD, 8'h01);
      wr(A_CAPH, 8'h80);
      wr(A_HI2, 8'h80);
      wr(A_T2CTL, 8'h06);
      pulse(P_C2);
      wt(2, 0, 40);
      rd(A_HI2, 8'hff);
      rd(A_T2CTL, 8'hc6);
      ck(oe === 1'b0, "event request in up/down");
      wr(A_T2CTL, 8'h06);
      @(posedge i_mclk);
      lvl[P_TG] <= 1'b1;
      pulse(P_C2);
      wt(2, 0, 40);
      rd(A_HI2, 8'h80);
      rd(A_T2CTL, 8'hc6);
      endt("up/down");
   endtask : t_ud

   task automatic t_baud;
      int n;
      int m;
      n = 0;
      m = 0;
      rst();
      wr(A_T2MD, 8'h02);
      wr(A_CKCTL, 8'h20);
      wr(A_CAPL, 8'hfe);
      wr(A_CAPH, 8'hff);
      wr(A_HI2, 8'hff);
      wr(A_LO2, 8'hff);
      wr(A_T2CTL, 8'h1c);
      wt(4, 0, 30);
      while (oc === 1'b1 && n < 50) begin
         @(posedge i_mclk);
         #1 n++;
      end
      while (oc === 1'b0 && m < 50) begin
         @(posedge i_mclk);
         #1 m++;
      end
      ck(n == 8 && m == 8, "clock out duty");
      ck(o2 === 1'b0, "overflow flag in baud mode");
      pulse(P_TG);
      wt(3, 0, 40);
      endt("baud");
   endtask : t_baud

   // ==========================================================
   // Closing report
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // Hang guard
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_regs();
      t_m0();
      t_m1();
      t_m2();
      t_gate();
      t_pin();
      t_m3();
      t_cap();
      t_rel();
      t_ud();
      t_baud();
      tally_and_finish();
   end
endmodule : three_timer_counter_unit_bench
